// *** include/gsp_pkg.sv ***
// Purpose: shared constants, types and carriers of the gateway status block
// Assumes: 100 MHz system clock, 32-bit APB register bus
// Notes: timing counts derive from times in their own units
package gsp_pkg;
	// ========================================
	// timing
	localparam longint CLK_HZ = 100_000_000;
	localparam longint WARN_TIME_S = 60;
	localparam longint WARN_CYC = WARN_TIME_S * CLK_HZ;
	localparam longint BLINK_MS = 250;
	localparam longint BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
	localparam longint POLL_TO_MS = 10;
	localparam longint POLL_TO_CYC = POLL_TO_MS * (CLK_HZ / 1000);
	localparam int WARN_CNT_W = 36;
	localparam int TMR_W = 28;
	// ========================================
	// sizes
	localparam int NUM_SLOTS = 4;
	localparam int SLOT_W = 2;
	localparam int CODE_W = 4;
	localparam int POS_W = 32;
	localparam logic [SLOT_W-1:0] SLOT_LAST = 2'h3;
	// ========================================
	// register map (byte addresses)
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_STATE = 12'h004;
	localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
	localparam logic [11:0] ADDR_IRQ_MASK = 12'h00c;
	localparam logic [11:0] ADDR_EVENT = 12'h010;
	localparam logic [11:0] ADDR_POS0 = 12'h020;
	localparam logic [11:0] ADDR_POS3 = 12'h02c;
	// ctrl: bit0 poll enable, bits 2:1 highest polled slot
	localparam int CTRL_POLL_EN = 0;
	localparam int CTRL_LAST_LSB = 1;
	localparam int CTRL_W = 3;
	localparam logic [CTRL_W-1:0] CTRL_RST = 3'h7;
	// state word fields
	localparam int ST_CODE_LSB = 0;
	localparam int ST_FATAL = 4;
	localparam int ST_WARN = 5;
	localparam int ST_SLOT_LSB = 6;
	localparam int ST_EXCH = 8;
	localparam int ST_ADDR_LSB = 16;
	// interrupt bits
	localparam int IRQ_FATAL = 0;
	localparam int IRQ_WARN = 1;
	localparam int IRQ_SWEEP = 2;
	localparam int IRQ_W = 3;
	// ========================================
	// event codes
	localparam logic [3:0] EV_NONE = 4'h0;
	localparam logic [3:0] EV_HW = 4'h1;
	localparam logic [3:0] EV_NVM = 4'h2;
	localparam logic [3:0] EV_MEM = 4'h3;
	localparam logic [3:0] EV_FB_HW = 4'h4;
	localparam logic [3:0] EV_SCRIPT = 4'h5;
	localparam logic [3:0] EV_RSV6 = 4'h6;
	localparam logic [3:0] EV_TX_OVF = 4'h7;
	localparam logic [3:0] EV_RX_OVF = 4'h8;
	localparam logic [3:0] EV_TIMEOUT = 4'h9;
	localparam logic [3:0] EV_FB_GEN = 4'ha;
	localparam logic [3:0] EV_PARITY = 4'hb;
	localparam logic [3:0] EV_RSV12 = 4'hc;
	localparam logic [3:0] EV_FB_CFG = 4'hd;
	localparam logic [3:0] EV_FB_OVF = 4'he;
	localparam logic [3:0] EV_RSV15 = 4'hf;
	localparam logic [3:0] FATAL_MAX = 4'h5;
	// station address limit and spare switch home
	localparam logic [7:0] STATION_MAX = 8'h7d;
	localparam logic [3:0] SPARE_HOME = 4'h0;
	// ========================================
	// types
	typedef enum logic [3:0] {
		PH_WAIT_PRM = 4'b0001,
		PH_WAIT_CFG = 4'b0010,
		PH_DATA_EXCH = 4'b0100,
		PH_ERROR = 4'b1000
	} gsp_phase_e;
	typedef enum logic [3:0] {
		PS_IDLE = 4'b0001,
		PS_REQ = 4'b0010,
		PS_WAIT = 4'b0100,
		PS_NEXT = 4'b1000
	} gsp_poll_e;
	typedef struct packed {
		logic valid;
		logic [CODE_W-1:0] code;
	} gsp_event_s;
	typedef struct packed {
		logic state_green;
		logic state_red;
		logic [CODE_W-1:0] code_indicator_leds;
	} gsp_led_s;
	typedef struct packed {
		logic bus_red;
		logic phase_green;
		logic phase_red;
	} gsp_fb_led_s;
endpackage : gsp_pkg

// *** src/gsp_gateway.sv ***
// Purpose: sensor polling, event display and fieldbus status of the gateway
// Assumes: SYS_RST is asserted at power-up; APB slave with zero wait states
// Notes: warning and poll timeout counts are parameters for short simulations
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - poll up to four sensor slots, numbered 0 to 3
// - poll positions continuously and always present the latest data
// - good exchange: state green, code leds one-hot by polled slot
// - on error or warning: state red, code shown in binary 8-4-2-1
// - current event code goes to the master in the diagnostic byte
// - codes 1 to 5 are fatal and stay until power cycles
// - codes 7 to 11, 13 and 14 are warnings, cleared alone after one minute
// - fatal codes: hardware, nvm, memory, fieldbus or address, script
// - warning codes 7,8,9,10,11,13,14; codes 0,6,12,15 reserved
// - bus led red whenever no cyclic exchange with the master
// - phase led: green, red/green flash, green flash, or red
// - station address is upper switch digit then lower switch digit
// - switches are sampled only once after power-up
module gsp_gateway #(
	parameter logic [gsp_pkg::WARN_CNT_W-1:0] WARN_CYCLES =
		gsp_pkg::WARN_CYC[gsp_pkg::WARN_CNT_W-1:0],
	parameter logic [gsp_pkg::TMR_W-1:0] BLINK_CYCLES =
		gsp_pkg::BLINK_CYC[gsp_pkg::TMR_W-1:0],
	parameter logic [gsp_pkg::TMR_W-1:0] POLL_TO_CYCLES =
		gsp_pkg::POLL_TO_CYC[gsp_pkg::TMR_W-1:0]
) (
	// clock and reset
	input wire logic MCLK,
	input wire logic SYS_RST,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output logic IRQ,
	// front panel switches
	input wire logic [3:0] ADDRESS_UPPER_DIGIT_SWITCH,
	input wire logic [3:0] ADDRESS_LOWER_DIGIT_SWITCH,
	input wire logic [3:0] SPARE_SWITCH_A,
	input wire logic [3:0] SPARE_SWITCH_B,
	// sensor side
	output logic POLL_REQ,
	output logic [gsp_pkg::SLOT_W-1:0] POLL_SLOT,
	input wire logic POLL_ACK,
	input wire logic [gsp_pkg::POS_W-1:0] POLL_POS,
	// events from the rest of the gateway
	input wire gsp_pkg::gsp_event_s EVENT,
	// fieldbus side
	input wire gsp_pkg::gsp_phase_e FB_PHASE,
	output logic [7:0] STATION_ADDR,
	output logic EXCH_ENABLE,
	output logic [7:0] EXT_DIAG,
	output logic [gsp_pkg::NUM_SLOTS*gsp_pkg::POS_W-1:0] SENSOR_DATA,
	// indicators
	output gsp_pkg::gsp_led_s LEDS,
	output gsp_pkg::gsp_fb_led_s FB_LEDS
);

	// ========================================
	// helpers
	function automatic logic is_reserved(input logic [3:0] c);
		is_reserved = (c == gsp_pkg::EV_NONE) || (c == gsp_pkg::EV_RSV6) ||
			(c == gsp_pkg::EV_RSV12) || (c == gsp_pkg::EV_RSV15);
	endfunction : is_reserved

	function automatic logic is_fatal(input logic [3:0] c);
		is_fatal = (c != gsp_pkg::EV_NONE) && (c <= gsp_pkg::FATAL_MAX);
	endfunction : is_fatal

	// ========================================
	// declarations
	logic [gsp_pkg::CTRL_W-1:0] ctrl_ff;
	logic [gsp_pkg::IRQ_W-1:0] irq_stat_ff;
	logic [gsp_pkg::IRQ_W-1:0] irq_mask_ff;
	logic [gsp_pkg::IRQ_W-1:0] irq_set;
	logic [31:0] nxt_prdata;
	logic nxt_pslverr;
	logic [31:0] prdata_ff;
	logic pslverr_ff;
	logic wr_en;
	logic sw_ev_ff;
	logic [3:0] sw_code_ff;
	logic cap_done_ff;
	logic [7:0] station_ff;
	logic spare_ok_ff;
	logic addr_bad_ff;
	gsp_pkg::gsp_poll_e poll_ff;
	logic [gsp_pkg::SLOT_W-1:0] slot_ff;
	logic [gsp_pkg::TMR_W-1:0] to_cnt_ff;
	logic timeout_ev;
	logic sweep_ev;
	logic [gsp_pkg::POS_W-1:0] pos_ff [gsp_pkg::NUM_SLOTS];
	logic ev_valid;
	logic [3:0] ev_code;
	logic [3:0] code_ff;
	logic fatal_ff;
	logic warn_ff;
	logic [gsp_pkg::WARN_CNT_W-1:0] warn_cnt_ff;
	logic [gsp_pkg::TMR_W-1:0] blink_cnt_ff;
	logic blink_ff;
	gsp_pkg::gsp_led_s nxt_leds;
	gsp_pkg::gsp_led_s leds_ff;
	gsp_pkg::gsp_fb_led_s nxt_fb_leds;
	gsp_pkg::gsp_fb_led_s fb_leds_ff;
	logic [7:0] diag_ff;
	logic poll_en;
	logic [gsp_pkg::SLOT_W-1:0] slot_last;

	assign poll_en = ctrl_ff[gsp_pkg::CTRL_POLL_EN];
	assign slot_last = ctrl_ff[gsp_pkg::CTRL_LAST_LSB +: gsp_pkg::SLOT_W];

	// ========================================
	// apb register access
	assign wr_en = PSEL && PENABLE && PWRITE;
	assign PREADY = 1'b1;
	assign PRDATA = prdata_ff;
	assign PSLVERR = pslverr_ff;

	always_comb begin
		nxt_prdata = 32'h0;
		nxt_pslverr = 1'b0;
		if (PADDR == gsp_pkg::ADDR_CTRL) begin
			nxt_prdata[gsp_pkg::CTRL_W-1:0] = ctrl_ff;
		end else if (PADDR == gsp_pkg::ADDR_STATE) begin
			nxt_prdata[gsp_pkg::ST_CODE_LSB +: 4] = code_ff;
			nxt_prdata[gsp_pkg::ST_FATAL] = fatal_ff;
			nxt_prdata[gsp_pkg::ST_WARN] = warn_ff;
			nxt_prdata[gsp_pkg::ST_SLOT_LSB +: gsp_pkg::SLOT_W] = slot_ff;
			nxt_prdata[gsp_pkg::ST_EXCH] = spare_ok_ff;
			nxt_prdata[gsp_pkg::ST_ADDR_LSB +: 8] = station_ff;
		end else if (PADDR == gsp_pkg::ADDR_IRQ_STAT) begin
			nxt_prdata[gsp_pkg::IRQ_W-1:0] = irq_stat_ff;
		end else if (PADDR == gsp_pkg::ADDR_IRQ_MASK) begin
			nxt_prdata[gsp_pkg::IRQ_W-1:0] = irq_mask_ff;
		end else if (PADDR == gsp_pkg::ADDR_EVENT) begin
			nxt_prdata[3:0] = sw_code_ff;
		end else if (PADDR >= gsp_pkg::ADDR_POS0 && PADDR <= gsp_pkg::ADDR_POS3 &&
				PADDR[1:0] == 2'h0) begin
			nxt_prdata = pos_ff[PADDR[3:2]];
		end else begin
			nxt_pslverr = 1'b1;
		end
	end

	// read data settles in the setup cycle, so the access needs no wait
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			prdata_ff <= 32'h0;
			pslverr_ff <= 1'b0;
		end else if (PSEL && !PENABLE) begin
			prdata_ff <= PWRITE ? 32'h0 : nxt_prdata;
			pslverr_ff <= nxt_pslverr;
		end
	end

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			ctrl_ff <= gsp_pkg::CTRL_RST;
			irq_mask_ff <= '0;
			sw_ev_ff <= 1'b0;
			sw_code_ff <= gsp_pkg::EV_NONE;
		end else begin
			sw_ev_ff <= 1'b0;
			if (wr_en && PADDR == gsp_pkg::ADDR_CTRL) begin
				ctrl_ff <= PWDATA[gsp_pkg::CTRL_W-1:0];
			end
			if (wr_en && PADDR == gsp_pkg::ADDR_IRQ_MASK) begin
				irq_mask_ff <= PWDATA[gsp_pkg::IRQ_W-1:0];
			end
			if (wr_en && PADDR == gsp_pkg::ADDR_EVENT) begin
				sw_code_ff <= PWDATA[3:0];
				sw_ev_ff <= 1'b1;
			end
		end
	end

	// ========================================
	// interrupts: sticky, write one to clear, set wins
	assign irq_set[gsp_pkg::IRQ_FATAL] = ev_valid && is_fatal(ev_code) && !fatal_ff;
	assign irq_set[gsp_pkg::IRQ_WARN] = ev_valid && !is_fatal(ev_code) && !fatal_ff;
	assign irq_set[gsp_pkg::IRQ_SWEEP] = sweep_ev;

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			irq_stat_ff <= '0;
		end else if (wr_en && PADDR == gsp_pkg::ADDR_IRQ_STAT) begin
			irq_stat_ff <= (irq_stat_ff & ~PWDATA[gsp_pkg::IRQ_W-1:0]) | irq_set;
		end else begin
			irq_stat_ff <= irq_stat_ff | irq_set;
		end
	end

	assign IRQ = |(irq_stat_ff & irq_mask_ff);

	// ========================================
	// power-up capture of the switches
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			cap_done_ff <= 1'b0;
			station_ff <= 8'h0;
			spare_ok_ff <= 1'b0;
			addr_bad_ff <= 1'b0;
		end else begin
			addr_bad_ff <= 1'b0;
			if (!cap_done_ff) begin
				cap_done_ff <= 1'b1;
				station_ff <= {ADDRESS_UPPER_DIGIT_SWITCH, ADDRESS_LOWER_DIGIT_SWITCH};
				spare_ok_ff <= (SPARE_SWITCH_A == gsp_pkg::SPARE_HOME) &&
					(SPARE_SWITCH_B == gsp_pkg::SPARE_HOME);
				addr_bad_ff <= {ADDRESS_UPPER_DIGIT_SWITCH, ADDRESS_LOWER_DIGIT_SWITCH} >
					gsp_pkg::STATION_MAX;
			end
		end
	end

	assign STATION_ADDR = station_ff;
	assign EXCH_ENABLE = spare_ok_ff;

	// ========================================
	// sensor polling sequencer
	assign POLL_REQ = (poll_ff == gsp_pkg::PS_REQ);
	assign POLL_SLOT = slot_ff;
	assign timeout_ev = (poll_ff == gsp_pkg::PS_WAIT) && !POLL_ACK && (to_cnt_ff == '0);
	assign sweep_ev = (poll_ff == gsp_pkg::PS_NEXT) && (slot_ff == slot_last);

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			poll_ff <= gsp_pkg::PS_IDLE;
			slot_ff <= '0;
			to_cnt_ff <= '0;
		end else begin
			case (poll_ff)
				gsp_pkg::PS_IDLE: begin
					slot_ff <= '0;
					if (poll_en) begin
						poll_ff <= gsp_pkg::PS_REQ;
					end
				end
				gsp_pkg::PS_REQ: begin
					to_cnt_ff <= POLL_TO_CYCLES - 1'b1;
					poll_ff <= gsp_pkg::PS_WAIT;
				end
				gsp_pkg::PS_WAIT: begin
					to_cnt_ff <= to_cnt_ff - 1'b1;
					if (POLL_ACK || to_cnt_ff == '0) begin
						poll_ff <= gsp_pkg::PS_NEXT;
					end
				end
				gsp_pkg::PS_NEXT: begin
					// wrap after the highest enabled slot
					slot_ff <= (slot_ff >= slot_last || slot_ff == gsp_pkg::SLOT_LAST) ?
						'0 : slot_ff + 1'b1;
					poll_ff <= poll_en ? gsp_pkg::PS_REQ : gsp_pkg::PS_IDLE;
				end
				default: begin
					poll_ff <= gsp_pkg::PS_IDLE;
				end
			endcase
		end
	end

	// latest position per slot, kept across timeouts
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			for (int i = 0; i < gsp_pkg::NUM_SLOTS; i++) begin
				pos_ff[i] <= '0;
			end
		end else if (poll_ff == gsp_pkg::PS_WAIT && POLL_ACK) begin
			pos_ff[slot_ff] <= POLL_POS;
		end
	end

	always_comb begin
		for (int i = 0; i < gsp_pkg::NUM_SLOTS; i++) begin
			SENSOR_DATA[i*gsp_pkg::POS_W +: gsp_pkg::POS_W] = pos_ff[i];
		end
	end

	// ========================================
	// event selection and classification
	always_comb begin
		ev_valid = 1'b0;
		ev_code = gsp_pkg::EV_NONE;
		if (addr_bad_ff) begin
			ev_valid = 1'b1;
			ev_code = gsp_pkg::EV_FB_HW;
		end else if (EVENT.valid && !is_reserved(EVENT.code)) begin
			ev_valid = 1'b1;
			ev_code = EVENT.code;
		end else if (sw_ev_ff && !is_reserved(sw_code_ff)) begin
			ev_valid = 1'b1;
			ev_code = sw_code_ff;
		end else if (timeout_ev) begin
			ev_valid = 1'b1;
			ev_code = gsp_pkg::EV_TIMEOUT;
		end
	end

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			code_ff <= gsp_pkg::EV_NONE;
			fatal_ff <= 1'b0;
			warn_ff <= 1'b0;
			warn_cnt_ff <= '0;
		end else if (fatal_ff) begin
			warn_ff <= 1'b0;
		end else if (ev_valid && is_fatal(ev_code)) begin
			code_ff <= ev_code;
			fatal_ff <= 1'b1;
			warn_ff <= 1'b0;
		end else if (ev_valid) begin
			code_ff <= ev_code;
			warn_ff <= 1'b1;
			warn_cnt_ff <= '0;
		end else if (warn_ff) begin
			if (warn_cnt_ff == WARN_CYCLES - 1'b1) begin
				warn_ff <= 1'b0;
				code_ff <= gsp_pkg::EV_NONE;
			end else begin
				warn_cnt_ff <= warn_cnt_ff + 1'b1;
			end
		end
	end

	// ========================================
	// sensor-side indicators and diagnostic byte
	always_comb begin
		nxt_leds.state_red = fatal_ff || warn_ff;
		nxt_leds.state_green = !(fatal_ff || warn_ff) && poll_en;
		if (fatal_ff || warn_ff) begin
			nxt_leds.code_indicator_leds = code_ff;
		end else if (poll_en) begin
			nxt_leds.code_indicator_leds = 4'h1 << slot_ff;
		end else begin
			nxt_leds.code_indicator_leds = 4'h0;
		end
	end

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			leds_ff <= '0;
			diag_ff <= 8'h0;
		end else begin
			leds_ff <= nxt_leds;
			diag_ff <= {4'h0, code_ff};
		end
	end

	assign LEDS = leds_ff;
	assign EXT_DIAG = diag_ff;

	// ========================================
	// fieldbus indicators
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			blink_cnt_ff <= '0;
			blink_ff <= 1'b0;
		end else if (blink_cnt_ff == BLINK_CYCLES - 1'b1) begin
			blink_cnt_ff <= '0;
			blink_ff <= !blink_ff;
		end else begin
			blink_cnt_ff <= blink_cnt_ff + 1'b1;
		end
	end

	always_comb begin
		nxt_fb_leds.bus_red = (FB_PHASE != gsp_pkg::PH_DATA_EXCH);
		case (FB_PHASE)
			gsp_pkg::PH_DATA_EXCH: begin
				nxt_fb_leds.phase_green = 1'b1;
				nxt_fb_leds.phase_red = 1'b0;
			end
			gsp_pkg::PH_WAIT_PRM: begin
				nxt_fb_leds.phase_green = blink_ff;
				nxt_fb_leds.phase_red = !blink_ff;
			end
			gsp_pkg::PH_WAIT_CFG: begin
				nxt_fb_leds.phase_green = blink_ff;
				nxt_fb_leds.phase_red = 1'b0;
			end
			default: begin
				nxt_fb_leds.phase_green = 1'b0;
				nxt_fb_leds.phase_red = 1'b1;
			end
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			fb_leds_ff <= '0;
		end else begin
			fb_leds_ff <= nxt_fb_leds;
		end
	end

	assign FB_LEDS = fb_leds_ff;

endmodule : gsp_gateway

`default_nettype wire

// *** verification/gsp_sensor_model.sv ***
// Purpose: behavioural sensor link partner answering position polls
// Assumes: one poll outstanding at a time, answer within the poll timeout
// Notes: mute drops every answer, slow delays it by four more cycles
`timescale 1ns/1ps
`default_nettype none
module gsp_sensor_model (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// poll link
	input wire logic poll_req,
	input wire logic [gsp_pkg::SLOT_W-1:0] poll_slot,
	output logic poll_ack,
	output logic [gsp_pkg::POS_W-1:0] poll_pos,
	// scenario controls
	input wire logic mute,
	input wire logic slow
);
	logic busy;
	logic [2:0] wait_cnt;
	logic [gsp_pkg::SLOT_W-1:0] slot;
	logic [15:0] seq;
	// ========================================
	// answer one poll per request
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			busy <= 1'b0;
			seq <= 16'h0000;
			poll_ack <= 1'b0;
			poll_pos <= 32'h5a5a_5a5a;
		end else begin
			poll_ack <= busy && wait_cnt == 3'h0;
			if (busy && wait_cnt == 3'h0) begin
				poll_pos <= {8'ha0 + {6'h00, slot}, 8'h00, seq};
				seq <= seq + 16'h0001;
				busy <= 1'b0;
			end else if (poll_ack) begin
				// released data line does not keep its value
				poll_pos <= ~poll_pos;
			end
			if (busy && wait_cnt != 3'h0) begin
				wait_cnt <= wait_cnt - 3'h1;
			end else if (!busy && poll_req && !mute) begin
				busy <= 1'b1;
				slot <= poll_slot;
				wait_cnt <= slow ? 3'h4 : 3'h0;
			end
		end
	end
endmodule : gsp_sensor_model
`default_nettype wire

// *** verification/gsp_gateway_chk.sv ***
// Purpose: port assertions of the gateway status block
// Assumes: one clock domain, synchronous active high reset
// Notes: the bind sits below the module
`timescale 1ns/1ps
`default_nettype none
module gsp_gateway_chk #(
	parameter logic [gsp_pkg::WARN_CNT_W-1:0] WARN_CYCLES =
		gsp_pkg::WARN_CYC[gsp_pkg::WARN_CNT_W-1:0]
) (
	// clock and reset
	input wire logic MCLK,
	input wire logic SYS_RST,
	// observed ports
	input wire logic POLL_REQ,
	input wire logic [gsp_pkg::SLOT_W-1:0] POLL_SLOT,
	input wire logic POLL_ACK,
	input wire gsp_pkg::gsp_event_s EVENT,
	input wire gsp_pkg::gsp_phase_e FB_PHASE,
	input wire logic [7:0] STATION_ADDR,
	input wire logic EXCH_ENABLE,
	input wire logic [7:0] EXT_DIAG,
	input wire gsp_pkg::gsp_led_s LEDS,
	input wire gsp_pkg::gsp_fb_led_s FB_LEDS
);
	logic fatal_shown;
	logic warn_shown;
	logic ev_warn;
	logic acked_ff;
	logic [1:0] up_ff;
	logic [gsp_pkg::WARN_CNT_W-1:0] warn_ff;
	assign fatal_shown = LEDS.state_red && LEDS.code_indicator_leds != 4'h0 &&
		LEDS.code_indicator_leds <= gsp_pkg::FATAL_MAX;
	assign warn_shown = LEDS.state_red && LEDS.code_indicator_leds > gsp_pkg::FATAL_MAX;
	assign ev_warn = EVENT.valid && EVENT.code > gsp_pkg::FATAL_MAX &&
		EVENT.code != 4'h6 && EVENT.code != 4'hc && EVENT.code != 4'hf;
	// ========================================
	// cycles since reset release, saturating
	always_ff @(posedge MCLK) begin
		if (SYS_RST)
			up_ff <= 2'h0;
		else if (up_ff != 2'h3)
			up_ff <= up_ff + 2'h1;
	end
	// ========================================
	// last poll answered
	always_ff @(posedge MCLK) begin
		if (SYS_RST)
			acked_ff <= 1'b1;
		else if (POLL_REQ)
			acked_ff <= 1'b0;
		else if (POLL_ACK)
			acked_ff <= 1'b1;
	end
	// ========================================
	// age of the shown warning
	always_ff @(posedge MCLK) begin
		if (SYS_RST || !warn_shown || EVENT.valid || (POLL_REQ && !acked_ff))
			warn_ff <= '0;
		else
			warn_ff <= warn_ff + 1'b1;
	end
	// ========================================
	// assertions
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (SYS_RST);
	sequence s_red_code;
		##2 (LEDS.state_red && LEDS.code_indicator_leds == $past(EVENT.code, 2));
	endsequence
	sequence s_fatal_in;
		EVENT.valid && EVENT.code != 4'h0 && EVENT.code <= gsp_pkg::FATAL_MAX && !fatal_shown;
	endsequence
	sequence s_warn_in;
		ev_warn && !fatal_shown;
	endsequence
	a_poll_pulse: assert property (POLL_REQ |=> !POLL_REQ && $stable(POLL_SLOT))
		else $error("poll request longer than one cycle or slot moved");
	a_fatal_display: assert property (s_fatal_in |-> s_red_code)
		else $error("fatal code not shown in red");
	a_warn_display: assert property (s_warn_in |-> s_red_code)
		else $error("warning code not shown in red");
	a_fatal_sticky: assert property (fatal_shown |=> $stable(LEDS) && $stable(EXT_DIAG))
		else $error("fatal indication changed before reset");
	a_warn_expiry: assert property (warn_ff <= WARN_CYCLES + 36'h8)
		else $error("warning shown too long");
	a_diag_code: assert property (EXT_DIAG == (LEDS.state_red ? {4'h0, LEDS.code_indicator_leds} : 8'h00))
		else $error("diagnostic byte differs from shown code");
	a_green_onehot: assert property (LEDS.state_green |-> !LEDS.state_red && $onehot(LEDS.code_indicator_leds))
		else $error("green state without one-hot slot");
	a_bus_red: assert property (EXCH_ENABLE |=> FB_LEDS.bus_red == ($past(FB_PHASE) != gsp_pkg::PH_DATA_EXCH))
		else $error("bus led wrong for phase");
	a_phase_steady: assert property (EXCH_ENABLE && FB_PHASE == gsp_pkg::PH_DATA_EXCH |=> FB_LEDS.phase_green && !FB_LEDS.phase_red)
		else $error("phase led not steady green");
	a_phase_error: assert property (FB_PHASE == gsp_pkg::PH_ERROR |=> FB_LEDS.phase_red && !FB_LEDS.phase_green)
		else $error("phase led not steady red");
	a_addr_frozen: assert property (up_ff == 2'h3 |-> $stable(STATION_ADDR) && $stable(EXCH_ENABLE))
		else $error("station address changed after power-up");
endmodule : gsp_gateway_chk
bind gsp_gateway gsp_gateway_chk #(.WARN_CYCLES(WARN_CYCLES)) gsp_gateway_chk_i (
	.MCLK(MCLK), .SYS_RST(SYS_RST), .POLL_REQ(POLL_REQ), .POLL_SLOT(POLL_SLOT),
	.POLL_ACK(POLL_ACK), .EVENT(EVENT), .FB_PHASE(FB_PHASE), .STATION_ADDR(STATION_ADDR),
	.EXCH_ENABLE(EXCH_ENABLE), .EXT_DIAG(EXT_DIAG), .LEDS(LEDS), .FB_LEDS(FB_LEDS));
`default_nettype wire

// *** verification/gsp_gateway_test.sv ***
// Purpose: self-checking bench of the gateway status block
// Assumes: zero wait APB, shortened warning, blink and poll timeout counts
// Notes: sensors come from the partner model, events and phases from here
`timescale 1ns/1ps
`default_nettype none
module gsp_gateway_test;
	localparam int WARN_WAIT = 70;
	logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, irq;
	logic poll_req, poll_ack, exch_enable, er, mute, slow;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, poll_pos;
	logic [3:0] up_sw, lo_sw, sp_a, sp_b, seen;
	logic [1:0] poll_slot;
	logic [7:0] station_addr, ext_diag;
	logic [127:0] sensor_data;
	logic [31:0] first [4];
	logic [2:0] fb_seen;
	logic [3:0] warn_codes [7] = '{4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hd, 4'he};
	gsp_pkg::gsp_phase_e phases [4] = '{gsp_pkg::PH_WAIT_PRM, gsp_pkg::PH_WAIT_CFG,
		gsp_pkg::PH_DATA_EXCH, gsp_pkg::PH_ERROR};
	logic [2:0] fb_exp [4] = '{3'b111, 3'b101, 3'b100, 3'b011};
	gsp_pkg::gsp_event_s ev_in;
	gsp_pkg::gsp_phase_e fb_phase;
	gsp_pkg::gsp_led_s leds;
	gsp_pkg::gsp_fb_led_s fb_leds;
	int miscompares, checks;
	gsp_gateway #(.WARN_CYCLES(36'h0_0000_0032), .BLINK_CYCLES(28'h000_0004),
		.POLL_TO_CYCLES(28'h000_0008)) gsp_gateway_i (
		.MCLK(mclk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.IRQ(irq), .ADDRESS_UPPER_DIGIT_SWITCH(up_sw), .ADDRESS_LOWER_DIGIT_SWITCH(lo_sw),
		.SPARE_SWITCH_A(sp_a), .SPARE_SWITCH_B(sp_b), .POLL_REQ(poll_req),
		.POLL_SLOT(poll_slot), .POLL_ACK(poll_ack), .POLL_POS(poll_pos), .EVENT(ev_in),
		.FB_PHASE(fb_phase), .STATION_ADDR(station_addr), .EXCH_ENABLE(exch_enable),
		.EXT_DIAG(ext_diag), .SENSOR_DATA(sensor_data), .LEDS(leds), .FB_LEDS(fb_leds));
	gsp_sensor_model gsp_sensor_model_i (.mclk(mclk), .sys_rst(sys_rst), .poll_req(poll_req),
		.poll_slot(poll_slot), .poll_ack(poll_ack), .poll_pos(poll_pos), .mute(mute), .slow(slow));
	// ========================================
	// shared tasks
	task chk(input logic [31:0] seen_v, input logic [31:0] exp_v, input string what);
		checks++;
		if (seen_v !== exp_v) begin
			miscompares++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, what, seen_v, exp_v);
		end
	endtask : chk
	task close_out;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out
	task cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask : cyc
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			miscompares++;
			close_out();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask : apb
	task ev(input logic [3:0] c);
		ev_in <= {1'b1, c};
		@(posedge mclk);
		ev_in <= '0;
		cyc(3);
	endtask : ev
	task shown(input logic [3:0] c);
		chk(32'(leds.state_red), 32'h1, "state red");
		chk(32'(leds.code_indicator_leds), 32'(c), "code leds");
		chk(32'(ext_diag), 32'(c), "diag byte");
	endtask : shown
	// ========================================
	// clock and watchdog
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		repeat (100000) @(posedge mclk);
		miscompares++;
		close_out();
	end
	// ========================================
	// main sequence
	initial begin
		sys_rst = 1'b1;
		{psel, penable, pwrite, mute, slow} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		up_sw = 4'h1;
		lo_sw = 4'h3;
		sp_a = 4'h0;
		sp_b = 4'h0;
		ev_in = '0;
		fb_phase = gsp_pkg::PH_DATA_EXCH;
		miscompares = 0;
		checks = 0;
		cyc(10);
		sys_rst <= 1'b0;
		cyc(4);
		up_sw <= 4'h7;
		lo_sw <= 4'he;
		slow <= 1'b1;
		cyc(300);
		apb(1'b0, gsp_pkg::ADDR_STATE, 32'h0);
		chk(32'(station_addr), 32'h13, "station address");
		chk(32'(rd[23:16]), 32'h13, "state station field");
		chk(32'(rd[8]), 32'h1, "exchange enabled");
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, gsp_pkg::ADDR_POS0 + 12'(4 * i), 32'h0);
			first[i] = rd;
			chk(32'(rd[31:24]), 32'(8'ha0 + i), "slot position");
			chk(32'(sensor_data[32 * i + 24 +: 8]), 32'(8'ha0 + i), "sensor data");
		end
		seen = 4'h0;
		repeat (64) begin
			@(posedge mclk);
			seen = seen | leds.code_indicator_leds;
		end
		chk(32'(seen), 32'hf, "slot display");
		chk(32'(leds.state_green), 32'h1, "state green");
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, gsp_pkg::ADDR_POS0 + 12'(4 * i), 32'h0);
			chk(32'(rd !== first[i]), 32'h1, "position refreshed");
		end
		slow <= 1'b0;
		$display("test poll done");
		apb(1'b1, gsp_pkg::ADDR_EVENT, 32'hb);
		cyc(3);
		shown(4'hb);
		foreach (warn_codes[i]) begin
			ev(warn_codes[i]);
			shown(warn_codes[i]);
		end
		foreach (fb_exp[i]) begin
			ev({i[1:0], 2'h0} ^ 4'h0 | (i == 0 ? 4'h0 : i == 1 ? 4'h6 : i == 2 ? 4'hc : 4'hf));
			chk(32'(leds.code_indicator_leds), 32'he, "reserved code ignored");
		end
		apb(1'b1, gsp_pkg::ADDR_IRQ_MASK, 32'h0);
		chk(32'(irq), 32'h0, "irq masked");
		apb(1'b0, gsp_pkg::ADDR_IRQ_STAT, 32'h0);
		chk(rd, 32'h6, "irq status");
		apb(1'b1, gsp_pkg::ADDR_IRQ_MASK, 32'h2);
		chk(32'(irq), 32'h1, "irq raised");
		apb(1'b1, gsp_pkg::ADDR_IRQ_STAT, 32'h2);
		chk(32'(irq), 32'h0, "irq cleared");
		cyc(WARN_WAIT);
		chk(32'(leds.state_red), 32'h0, "warning expired");
		chk(32'(leds.state_green), 32'h1, "slot display back");
		$display("test warnings done");
		mute <= 1'b1;
		cyc(40);
		shown(4'h9);
		mute <= 1'b0;
		cyc(WARN_WAIT + 40);
		chk(32'(leds.state_red), 32'h0, "timeout warning expired");
		$display("test timeout done");
		foreach (phases[i]) begin
			fb_phase <= phases[i];
			cyc(3);
			fb_seen = 3'b000;
			repeat (24) begin
				@(posedge mclk);
				fb_seen = fb_seen | {fb_leds.phase_green, fb_leds.phase_red, !fb_leds.phase_green};
			end
			chk(32'(fb_seen), 32'(fb_exp[i]), "phase led pattern");
			chk(32'(fb_leds.bus_red), 32'(i != 2), "bus led");
		end
		fb_phase <= gsp_pkg::PH_DATA_EXCH;
		apb(1'b0, 12'h100, 32'h0);
		chk(32'(er), 32'h1, "unmapped error");
		chk(rd, 32'h0, "unmapped read");
		apb(1'b1, 12'h100, 32'hffff_ffff);
		apb(1'b0, gsp_pkg::ADDR_CTRL, 32'h0);
		chk(32'(rd[2:0]), 32'h7, "control untouched");
		apb(1'b1, gsp_pkg::ADDR_CTRL, 32'h0);
		cyc(20);
		chk(32'(leds), 32'h0, "poll off display");
		$display("test fieldbus done");
		up_sw <= 4'h1;
		lo_sw <= 4'h3;
		for (int c = 1; c <= 5; c++) begin
			ev(4'(c));
			shown(4'(c));
			ev(4'h9);
			shown(4'(c));
			if (c == 5)
				cyc(WARN_WAIT);
			chk(32'(leds.code_indicator_leds), 32'(c), "fatal held");
			sys_rst <= 1'b1;
			cyc(2);
			sys_rst <= 1'b0;
			cyc(5);
			chk(32'(leds.state_red), 32'h0, "fatal cleared by reset");
		end
		up_sw <= 4'h8;
		sys_rst <= 1'b1;
		cyc(2);
		sys_rst <= 1'b0;
		cyc(5);
		shown(4'h4);
		$display("test fatal done");
		close_out();
	end
endmodule : gsp_gateway_test
`default_nettype wire
